/* fups_pkg.sv */
package fups_pkg;
    // byte offsets on the special-function register port
    localparam logic [7:0] OFS_FLASH_CONTROL_MAIN = 8'h73;
    localparam logic [7:0] OFS_BUFFER_CONTROL     = 8'h75;
    localparam logic [7:0] OFS_FLASH_ADDRESS_LOW  = 8'h76;
    localparam logic [7:0] OFS_FLASH_ADDRESS_HIGH = 8'h77;
    localparam logic [7:0] OFS_LOAD_DATA_LOW      = 8'h78;
    localparam logic [7:0] OFS_LOAD_DATA_HIGH     = 8'h79;
    localparam logic [7:0] OFS_KEY_LOW_FIRST      = 8'h7a;
    localparam logic [7:0] OFS_KEY_HIGH_FIRST     = 8'h7b;
    localparam logic [7:0] OFS_KEY_LOW_SECOND     = 8'h7c;
    localparam logic [7:0] OFS_KEY_HIGH_SECOND    = 8'h7d;
    localparam logic [7:0] OFS_KEY_LOW_THIRD      = 8'h7e;
    localparam logic [7:0] OFS_KEY_HIGH_THIRD     = 8'h7f;
    // control field positions and address-high field width
    localparam int BIT_PROGRAM_ENABLE = 7;
    localparam int MODE_LSB           = 4;
    localparam int BIT_UNLOCK_TRIGGER = 3;
    localparam int BIT_WRITE_INITIATE = 2;
    localparam int BIT_BUFFER_CLEAR   = 0;
    localparam int ADDR_HIGH_BITS     = 6;
    // op_mode_field codes
    localparam logic [2:0] MODE_WRITE  = 3'h0;
    localparam logic [2:0] MODE_ERASE  = 3'h1;
    localparam logic [2:0] MODE_UNLOCK = 3'h6;
    // unlock key bytes
    localparam logic [7:0] KEY_LOW_FIRST   = 8'h00;
    localparam logic [7:0] KEY_LOW_SECOND  = 8'h0d;
    localparam logic [7:0] KEY_LOW_THIRD   = 8'hc3;
    localparam logic [7:0] KEY_HIGH_FIRST  = 8'h04;
    localparam logic [7:0] KEY_HIGH_SECOND = 8'h09;
    localparam logic [7:0] KEY_HIGH_THIRD  = 8'h40;
    // reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [2:0]  RST_MODE    = 3'h0;
    localparam logic [13:0] RST_ADDRESS = 14'h0000;
    // geometry
    localparam int PAGE_WORDS = 64;
    localparam int WORD_BITS  = 6;
    localparam int ADDR_BITS  = 14;
    localparam logic [5:0] LAST_WORD = 6'h3f;
    // timing
    localparam int CLOCK_PERIOD_NS      = 10;
    localparam int BUSY_TIME_NS         = 2200000;
    localparam int BUSY_CYCLES          = BUSY_TIME_NS / CLOCK_PERIOD_NS;
    localparam int UNLOCK_WINDOW_CYCLES = 1000;
    localparam int UNLOCK_CNT_BITS      = 16;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_PROGRAM = 2'b01,
        ST_SETTLE  = 2'b11,
        ST_ERASE   = 2'b10
    } fups_state_t;
endpackage

/* fups_top.sv */
`timescale 1ns/10ps
module fups_top #(
    parameter int BUSY_CYCLES          = fups_pkg::BUSY_CYCLES,
    parameter int UNLOCK_WINDOW_CYCLES = fups_pkg::UNLOCK_WINDOW_CYCLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // register port
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    // cpu
    output logic             cpu_stall,
    // flash array
    output logic             flash_prog_en,
    output logic      [13:0] flash_prog_addr,
    output logic      [15:0] flash_prog_data,
    output logic             flash_erase_en,
    output logic      [7:0]  flash_erase_page
);
    localparam int BUSY_BITS = $clog2(BUSY_CYCLES + 1);
    localparam int UB        = fups_pkg::UNLOCK_CNT_BITS;

    fups_pkg::fups_state_t state_q, state_d;
    logic                  pe_q, pe_d;
    logic [2:0]            mode_q;
    logic                  unlock_q, unlock_d;
    logic [UB-1:0]         ucnt_q, ucnt_d;
    logic [BUSY_BITS-1:0]  bcnt_q, bcnt_d;
    logic                  clr_q;
    logic [13:0]           addr_q, addr_d;
    logic [7:0]            data_q [8];
    logic [63:0]           mask_q, mask_d;
    logic [5:0]            idx_q;
    logic [15:0]           wbuf [fups_pkg::PAGE_WORDS];

    // decode
    wire        wr_ctrl  = sfr_wr && sfr_addr == fups_pkg::OFS_FLASH_CONTROL_MAIN;
    wire        wr_bclr  = sfr_wr && sfr_addr == fups_pkg::OFS_BUFFER_CONTROL;
    wire        wr_alow  = sfr_wr && sfr_addr == fups_pkg::OFS_FLASH_ADDRESS_LOW;
    wire        wr_ahigh = sfr_wr && sfr_addr == fups_pkg::OFS_FLASH_ADDRESS_HIGH;
    wire        data_sel = sfr_addr[7:3] == fups_pkg::OFS_LOAD_DATA_LOW[7:3];
    wire        wr_data  = sfr_wr && data_sel;
    wire        busy     = state_q != fups_pkg::ST_IDLE;
    wire        load     = sfr_wr && sfr_addr == fups_pkg::OFS_LOAD_DATA_HIGH && !busy;
    wire [2:0]  new_mode = sfr_wdata[fups_pkg::MODE_LSB +: 3];
    wire [5:0]  word_idx = addr_q[fups_pkg::WORD_BITS-1:0];
    wire        at_last  = word_idx == fups_pkg::LAST_WORD;

    // unlock window
    wire unlock_expire = unlock_q && ucnt_q == UB'(UNLOCK_WINDOW_CYCLES - 1);
    wire sw_trig       = wr_ctrl && sfr_wdata[fups_pkg::BIT_UNLOCK_TRIGGER]
                         && new_mode == fups_pkg::MODE_UNLOCK && !busy;
    wire trig_start    = sw_trig && (!unlock_q || unlock_expire);
    wire key_ok =
        data_q[fups_pkg::OFS_KEY_LOW_FIRST[2:0]]   == fups_pkg::KEY_LOW_FIRST   &&
        data_q[fups_pkg::OFS_KEY_LOW_SECOND[2:0]]  == fups_pkg::KEY_LOW_SECOND  &&
        data_q[fups_pkg::OFS_KEY_LOW_THIRD[2:0]]   == fups_pkg::KEY_LOW_THIRD   &&
        data_q[fups_pkg::OFS_KEY_HIGH_FIRST[2:0]]  == fups_pkg::KEY_HIGH_FIRST  &&
        data_q[fups_pkg::OFS_KEY_HIGH_SECOND[2:0]] == fups_pkg::KEY_HIGH_SECOND &&
        data_q[fups_pkg::OFS_KEY_HIGH_THIRD[2:0]]  == fups_pkg::KEY_HIGH_THIRD;
    // key judged at window end, so a slow writer that finishes inside the window still passes
    wire pe_hw_set = unlock_expire && key_ok && mode_q == fups_pkg::MODE_UNLOCK;
    wire pe_sw_clr = wr_ctrl && !sfr_wdata[fups_pkg::BIT_PROGRAM_ENABLE];

    // operation start; refused silently without program enable
    wire start_ok = wr_ctrl && sfr_wdata[fups_pkg::BIT_WRITE_INITIATE] && pe_q
                    && sfr_wdata[fups_pkg::BIT_PROGRAM_ENABLE] && !busy
                    && (new_mode == fups_pkg::MODE_WRITE || new_mode == fups_pkg::MODE_ERASE);
    wire start_erase = start_ok && new_mode == fups_pkg::MODE_ERASE;
    wire busy_done   = state_q == fups_pkg::ST_SETTLE && bcnt_q == BUSY_BITS'(BUSY_CYCLES - 1);

    assign unlock_d = sw_trig || (unlock_q && !unlock_expire);
    assign ucnt_d   = (trig_start || !unlock_q) ? '0 : ucnt_q + UB'(1);
    assign pe_d     = pe_hw_set || (pe_q && !pe_sw_clr);
    assign bcnt_d   = start_ok ? '0 : (busy ? bcnt_q + BUSY_BITS'(1) : bcnt_q);

    // address pair: software writes, or auto-advance on a word load
    assign addr_d = wr_alow  ? {addr_q[13:8], sfr_wdata} :
                    wr_ahigh ? {sfr_wdata[fups_pkg::ADDR_HIGH_BITS-1:0], addr_q[7:0]} :
                    (load && !at_last) ? addr_q + 14'h0001 : addr_q;

    // a load beside the clear still lands, so back-to-back strobes lose no word
    assign mask_d = (clr_q ? 64'h0 : mask_q) | (load ? 64'h1 << word_idx : 64'h0);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            fups_pkg::ST_IDLE:
            begin
                if (start_ok)
                    state_d = start_erase ? fups_pkg::ST_ERASE : fups_pkg::ST_PROGRAM;
            end
            fups_pkg::ST_ERASE:   state_d = fups_pkg::ST_SETTLE;
            fups_pkg::ST_PROGRAM:
            begin
                if (idx_q == fups_pkg::LAST_WORD)
                    state_d = fups_pkg::ST_SETTLE;
            end
            fups_pkg::ST_SETTLE:
            begin
                if (busy_done)
                    state_d = fups_pkg::ST_IDLE;
            end
            default: state_d = fups_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            state_q  <= fups_pkg::ST_IDLE;
            pe_q     <= 1'b0;
            mode_q   <= fups_pkg::RST_MODE;
            unlock_q <= 1'b0;
            ucnt_q   <= '0;
            bcnt_q   <= '0;
            clr_q    <= 1'b0;
            addr_q   <= fups_pkg::RST_ADDRESS;
            mask_q   <= 64'h0;
        end
        else
        begin
            state_q  <= state_d;
            pe_q     <= pe_d;
            unlock_q <= unlock_d;
            ucnt_q   <= ucnt_d;
            bcnt_q   <= bcnt_d;
            clr_q    <= wr_bclr && sfr_wdata[fups_pkg::BIT_BUFFER_CLEAR];
            addr_q   <= addr_d;
            mask_q   <= mask_d;
            if (wr_ctrl && !busy)
                mode_q <= new_mode;
        end
    end

    // data and key byte registers
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 8; i++)
                data_q[i] <= fups_pkg::RST_BYTE;
        end
        else if (wr_data && !busy)
        begin
            data_q[sfr_addr[2:0]] <= sfr_wdata;
        end
    end

    // buffer words are kept after a write so a same-page retry needs no reload
    always_ff @(posedge clock)
    begin
        if (load)
            wbuf[word_idx] <= {sfr_wdata, data_q[fups_pkg::OFS_LOAD_DATA_LOW[2:0]]};
    end

    wire [7:0] ctrl_rd = {pe_q, mode_q, unlock_q, busy, 2'b00};
    wire [7:0] rd_mux  = (sfr_addr == fups_pkg::OFS_FLASH_CONTROL_MAIN) ? ctrl_rd :
                         (sfr_addr == fups_pkg::OFS_BUFFER_CONTROL) ? {7'h00, clr_q} :
                         (sfr_addr == fups_pkg::OFS_FLASH_ADDRESS_LOW) ? addr_q[7:0] :
                         (sfr_addr == fups_pkg::OFS_FLASH_ADDRESS_HIGH) ? {2'b00, addr_q[13:8]} :
                         data_sel ? data_q[sfr_addr[2:0]] : 8'h00;

    // flash array drive
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            idx_q            <= 6'h00;
            flash_prog_en    <= 1'b0;
            flash_prog_addr  <= fups_pkg::RST_ADDRESS;
            flash_prog_data  <= 16'h0000;
            flash_erase_en   <= 1'b0;
            flash_erase_page <= 8'h00;
            sfr_rdata        <= fups_pkg::RST_BYTE;
        end
        else
        begin
            idx_q            <= (state_q == fups_pkg::ST_PROGRAM) ? idx_q + 6'h01 : 6'h00;
            flash_prog_en    <= state_q == fups_pkg::ST_PROGRAM && mask_q[idx_q];
            flash_prog_addr  <= {addr_q[13:6], idx_q};
            flash_prog_data  <= wbuf[idx_q];
            flash_erase_en   <= start_erase;
            flash_erase_page <= addr_q[13:6];
            sfr_rdata        <= sfr_rd ? rd_mux : 8'h00;
        end
    end

    // stall follows the busy state so it covers the whole timed window
    assign cpu_stall = busy;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    a_unlock_mode: assert property (
        $rose(unlock_q) |-> mode_q == fups_pkg::MODE_UNLOCK)
        else $error("unlock armed outside unlock mode");

    a_unlock_timeout: assert property (
        unlock_expire && !sw_trig |=> !unlock_q)
        else $error("unlock trigger not cleared at timeout");

    a_pe_no_sw_set: assert property (
        wr_ctrl && !pe_q && !pe_hw_set |=> !pe_q)
        else $error("software set program enable");

    a_pe_sw_clear: assert property (
        pe_sw_clr && !pe_hw_set |=> !pe_q)
        else $error("program enable not cleared by software");

    a_no_pe_no_op: assert property (
        state_q == fups_pkg::ST_IDLE && !pe_q |=> state_q == fups_pkg::ST_IDLE && !flash_erase_en && !flash_prog_en)
        else $error("operation started without program enable");

    a_stall_on_start: assert property (
        start_ok |=> cpu_stall [*8])
        else $error("cpu not stalled after start");

    a_initiate_hold: assert property (
        $rose(busy) |-> busy [*8] ##0 bcnt_q == 7)
        else $error("write initiate dropped early");

    a_busy_length: assert property (
        $fell(busy) |-> $past(bcnt_q) == BUSY_BITS'(BUSY_CYCLES - 1))
        else $error("write initiate held for wrong time");

    a_pointer_hold: assert property (
        load && at_last |=> addr_q == $past(addr_q))
        else $error("pointer crossed page boundary");

    a_pointer_step: assert property (
        load && !at_last |=> addr_q == $past(addr_q) + 14'h0001 && mask_q[$past(word_idx)])
        else $error("pointer did not advance on word load");

    a_erase_page: assert property (
        start_erase |=> flash_erase_en && flash_erase_page == $past(addr_q[13:6]) ##1 !flash_erase_en)
        else $error("erase pulse or page wrong");

    a_buffer_clear: assert property (
        clr_q && !wr_bclr |=> !clr_q && mask_q == ($past(load) ? 64'h1 << $past(word_idx) : 64'h0))
        else $error("buffer clear did not finish");
endmodule // fups_top

/* fups_flash_model.sv */
`timescale 1ns/10ps
module fups_flash_model (
    // sequencer side
    input wire logic        clock,
    input wire logic        flash_prog_en,
    input wire logic [13:0] flash_prog_addr,
    input wire logic [15:0] flash_prog_data,
    input wire logic        flash_erase_en,
    input wire logic [7:0]  flash_erase_page
);
    logic [15:0] mem [0:16383];
    int          prog_count;
    int          erase_count;

    // unprogrammed cells start as ffff so an erase is visible
    initial
    begin
        prog_count  = 0;
        erase_count = 0;
        for (int i = 0; i < 16384; i++)
            mem[i] = 16'hffff;
    end

    always @(posedge clock)
    begin
        if (flash_prog_en === 1'b1)
        begin
            mem[flash_prog_addr] = flash_prog_data;
            prog_count++;
        end
        if (flash_erase_en === 1'b1)
        begin
            for (int i = 0; i < 64; i++)
                mem[{flash_erase_page, 6'(i)}] = 16'h0000;
            erase_count++;
        end
    end
endmodule // fups_flash_model

/* fups_top_tb.sv */
`timescale 1ns/10ps
module fups_top_tb;
    localparam int BUSY = 100;
    localparam int WIN  = 50;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_rdata;
    logic        cpu_stall;
    logic        flash_prog_en;
    logic [13:0] flash_prog_addr;
    logic [15:0] flash_prog_data;
    logic        flash_erase_en;
    logic [7:0]  flash_erase_page;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;

    always #5 clock = ~clock;

    fups_top #(.BUSY_CYCLES(BUSY), .UNLOCK_WINDOW_CYCLES(WIN)) i_fups_top (
        .clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cpu_stall(cpu_stall), .flash_prog_en(flash_prog_en),
        .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data),
        .flash_erase_en(flash_erase_en), .flash_erase_page(flash_erase_page));

    fups_flash_model i_fups_flash_model (
        .clock(clock), .flash_prog_en(flash_prog_en), .flash_prog_addr(flash_prog_addr),
        .flash_prog_data(flash_prog_data), .flash_erase_en(flash_erase_en),
        .flash_erase_page(flash_erase_page));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_addr  <= a;
        sfr_wdata <= d;
        sfr_wr    <= 1'b1;
        @(posedge clock);
        sfr_wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge clock);
        sfr_rd   <= 1'b0;
        #1;
        chk(what, {8'h00, exp}, {8'h00, sfr_rdata});
    endtask

    task automatic load(input logic [15:0] w);
        wr(fups_pkg::OFS_LOAD_DATA_LOW, w[7:0]);
        wr(fups_pkg::OFS_LOAD_DATA_HIGH, w[15:8]);
    endtask

    // start an operation and measure how long the cpu stays stalled
    task automatic op(input logic [7:0] ctrl, input int exp_cycles);
        int n;
        n = 0;
        wr(fups_pkg::OFS_FLASH_CONTROL_MAIN, ctrl);
        #1;
        while (cpu_stall === 1'b1 && n < 1000)
        begin
            n++;
            @(posedge clock);
            #1;
        end
        chk("stall cycles", 16'(exp_cycles), 16'(n));
        rd(fups_pkg::OFS_FLASH_CONTROL_MAIN, exp_cycles > 0 ? ctrl & 8'hfb : 8'h00, "control after op");
    endtask

    task automatic unlock(input logic [7:0] k0, input logic [7:0] exp);
        wr(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h68);
        rd(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h68, "trigger standing");
        wr(fups_pkg::OFS_KEY_LOW_FIRST, k0);
        wr(fups_pkg::OFS_KEY_LOW_SECOND, fups_pkg::KEY_LOW_SECOND);
        wr(fups_pkg::OFS_KEY_LOW_THIRD, fups_pkg::KEY_LOW_THIRD);
        wr(fups_pkg::OFS_KEY_HIGH_FIRST, fups_pkg::KEY_HIGH_FIRST);
        wr(fups_pkg::OFS_KEY_HIGH_SECOND, fups_pkg::KEY_HIGH_SECOND);
        wr(fups_pkg::OFS_KEY_HIGH_THIRD, fups_pkg::KEY_HIGH_THIRD);
        repeat (WIN + 4) @(posedge clock);
        rd(fups_pkg::OFS_FLASH_CONTROL_MAIN, exp, "control after window");
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h00, "control reset");
        wr(8'h74, 8'h55);
        rd(8'h74, 8'h00, "unmapped");
        done("reset and map");
        wr(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h80);
        rd(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h00, "enable not settable");
        wr(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h08);
        rd(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h00, "trigger needs mode");
        op(8'h84, 0);
        chk("no program", 16'h0000, 16'(i_fups_flash_model.prog_count));
        done("refusals");
        unlock(8'h11, 8'h60);
        unlock(fups_pkg::KEY_LOW_FIRST, 8'he0);
        done("unlock");
        wr(fups_pkg::OFS_FLASH_ADDRESS_HIGH, 8'h05);
        wr(fups_pkg::OFS_FLASH_ADDRESS_LOW, 8'h40);
        op(8'h94, BUSY);
        chk("erase count", 16'h0001, 16'(i_fups_flash_model.erase_count));
        chk("erased first", 16'h0000, i_fups_flash_model.mem[14'h0540]);
        chk("erased last", 16'h0000, i_fups_flash_model.mem[14'h057f]);
        chk("next page kept", 16'hffff, i_fups_flash_model.mem[14'h0580]);
        done("erase");
        wr(fups_pkg::OFS_FLASH_ADDRESS_LOW, 8'h7e);
        load(16'h1234);
        load(16'h5678);
        load(16'h9abc);
        rd(fups_pkg::OFS_FLASH_ADDRESS_LOW, 8'h7f, "pointer holds");
        rd(fups_pkg::OFS_FLASH_ADDRESS_HIGH, 8'h05, "page kept");
        op(8'h84, BUSY);
        chk("word 3e", 16'h1234, i_fups_flash_model.mem[14'h057e]);
        chk("word 3f", 16'h9abc, i_fups_flash_model.mem[14'h057f]);
        chk("prog count", 16'h0002, 16'(i_fups_flash_model.prog_count));
        done("write");
        wr(fups_pkg::OFS_BUFFER_CONTROL, 8'h01);
        rd(fups_pkg::OFS_BUFFER_CONTROL, 8'h00, "clear done");
        wr(fups_pkg::OFS_FLASH_ADDRESS_LOW, 8'h7e);
        load(16'h0e0f);
        rd(fups_pkg::OFS_LOAD_DATA_HIGH, 8'h0e, "high byte kept");
        op(8'h84, BUSY);
        chk("retry word", 16'h0e0f, i_fups_flash_model.mem[14'h057e]);
        chk("cleared word", 16'h0003, 16'(i_fups_flash_model.prog_count));
        chk("no erase", 16'h0001, 16'(i_fups_flash_model.erase_count));
        done("retry");
        wr(fups_pkg::OFS_FLASH_CONTROL_MAIN, 8'h00);
        op(8'h84, 0);
        chk("disabled", 16'h0003, 16'(i_fups_flash_model.prog_count));
        done("disable");
        results();
    end
endmodule // fups_top_tb
